// >>> src/dcm_pkg.sv
// constants, field layouts and helpers shared by the channel config block
// assumes a 100 MHz system clock and one register port per device
package dcm_pkg;

  // ---------------------------------------------------------------
  // register offsets (bit 3 of the address selects channel b)
  // ---------------------------------------------------------------
  localparam logic [3:0] DCM_OFF_MODE_A  = 4'h0;
  localparam logic [3:0] DCM_OFF_CSEL_A  = 4'h1;
  localparam logic [3:0] DCM_OFF_CMD_A   = 4'h2;
  localparam logic [3:0] DCM_OFF_STATE_A = 4'h3;
  localparam logic [3:0] DCM_OFF_AUX     = 4'h4;
  localparam logic [3:0] DCM_OFF_MODE_B  = 4'h8;
  localparam logic [3:0] DCM_OFF_CSEL_B  = 4'h9;
  localparam logic [3:0] DCM_OFF_CMD_B   = 4'ha;
  localparam logic [3:0] DCM_OFF_STATE_B = 4'hb;
  localparam int         DCM_CHAN_BIT    = 3;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         DCM_MR2_RTS_BIT  = 5;
  localparam int         DCM_MR2_CTS_BIT  = 4;
  localparam int         DCM_MR1_RXRTS    = 7;
  localparam int         DCM_AUX_SET_BIT  = 7;
  localparam logic [7:0] DCM_MODE_RESET   = 8'h00;
  localparam logic [7:0] DCM_CSEL_RESET   = 8'h00;
  localparam logic [3:0] DCM_CSEL_TIMER   = 4'hd;
  localparam logic [3:0] DCM_CSEL_PIN_16X = 4'he;
  localparam logic [3:0] DCM_CSEL_PIN_1X  = 4'hf;
  localparam logic [1:0] DCM_PAR_MULTIDROP = 2'h3;
  localparam logic [1:0] DCM_BITS_FIVE    = 2'h0;
  localparam logic [1:0] DCM_FIELD_ENABLE  = 2'h1;
  localparam logic [1:0] DCM_FIELD_DISABLE = 2'h2;

  // ---------------------------------------------------------------
  // baud rates in tenths of a bit per second, ascending
  // ---------------------------------------------------------------
  localparam int DCM_NUM_RATES = 18;
  localparam int unsigned DCM_RATE_X10 [DCM_NUM_RATES] = '{
    500, 750, 1100, 1345, 1500, 2000, 3000, 6000, 10500,
    12000, 18000, 20000, 24000, 48000, 72000, 96000, 192000, 384000};

  // miscellaneous command codes
  typedef enum logic [2:0] {
    DCM_MISC_NONE, DCM_MISC_PTR_RESET, DCM_MISC_RX_RESET, DCM_MISC_TX_RESET,
    DCM_MISC_ERR_RESET, DCM_MISC_BCHG_RESET, DCM_MISC_BREAK_START, DCM_MISC_BREAK_STOP
  } dcm_misc_t;

  // clock-select code and baud set to rate index
  function automatic logic [4:0] dcm_rate_index(input logic [3:0] code, input logic set2);
    case (code)
      4'h0:    return set2 ? 5'd1 : 5'd0;
      4'h1:    return 5'd2;
      4'h2:    return 5'd3;
      4'h3:    return set2 ? 5'd4 : 5'd5;
      4'h4:    return 5'd6;
      4'h5:    return 5'd7;
      4'h6:    return 5'd9;
      4'h7:    return set2 ? 5'd11 : 5'd8;
      4'h8:    return 5'd12;
      4'h9:    return 5'd13;
      4'ha:    return set2 ? 5'd10 : 5'd14;
      4'hb:    return 5'd15;
      4'hc:    return set2 ? 5'd16 : 5'd17;
      default: return 5'd0;
    endcase
  endfunction

  // stop length in sixteenths of a bit
  function automatic logic [5:0] dcm_stop_16ths(input logic [3:0] code, input logic five_bit,
                                                input logic ext_1x);
    if (ext_1x)
      return code[3] ? 6'd32 : 6'd16;
    else if (code[3])
      return 6'd25 + {3'h0, code[2:0]};
    else if (five_bit)
      return 6'd17 + {3'h0, code[2:0]};
    else
      return 6'd9 + {3'h0, code[2:0]};
  endfunction

endpackage

// >>> src/dcm_baud_gen.sv
// shared baud-rate generator: one 16x tick per rate from the system clock
// assumes CLK_HZ is far above sixteen times the fastest rate
`timescale 1ns/1ps
`default_nettype none
module dcm_baud_gen
  import dcm_pkg::*;
#(
  parameter int CLK_HZ = 100_000_000,
  parameter int CW     = 20
)(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // one-cycle 16x ticks, one per rate
  output logic     [DCM_NUM_RATES-1:0] tick
);

  typedef struct packed {
    logic [DCM_NUM_RATES-1:0][CW-1:0] cnt;
    logic [DCM_NUM_RATES-1:0]         tick;
  } dcm_bg_state_t;

  dcm_bg_state_t s;
  dcm_bg_state_t next_s;

  // divide ratio minus one, rounded to nearest
  function automatic logic [CW-1:0] dcm_div_last(input int i);
    longint d;
    d = (longint'(CLK_HZ) * 10 + 8 * longint'(DCM_RATE_X10[i])) / (16 * longint'(DCM_RATE_X10[i]));
    if (d < 1)
      d = 1;
    return CW'(d - 1);
  endfunction

  // free-running dividers
  always_comb
  begin
    next_s = s;
    for (int i = 0; i < DCM_NUM_RATES; i++)
    begin
      next_s.tick[i] = 1'b0;
      if (s.cnt[i] >= dcm_div_last(i))
      begin
        next_s.cnt[i]  = '0;
        next_s.tick[i] = 1'b1;
      end
      else
        next_s.cnt[i] = s.cnt[i] + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;

endmodule
`default_nettype wire

// >>> src/dcm_clk_sel.sv
// one receiver or transmitter clock selector
// assumes pin and timer inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dcm_clk_sel
  import dcm_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // selection
  input  wire logic [3:0]               code,
  input  wire logic                     set2,
  // sources
  input  wire logic [DCM_NUM_RATES-1:0] rate_tick,
  input  wire logic                     timer_out,
  input  wire logic                     pin,
  // selected clock
  output logic                          tick,
  output logic                          one_x
);

  typedef struct packed {
    logic pin_q;
    logic timer_q;
    logic tick;
    logic one_x;
  } dcm_cs_state_t;

  dcm_cs_state_t s;
  dcm_cs_state_t next_s;

  // source mux: pin edge, timer edge or generator tick
  always_comb
  begin
    next_s         = s;
    next_s.pin_q   = pin;
    next_s.timer_q = timer_out;
    next_s.one_x   = (code == DCM_CSEL_PIN_1X);
    case (code)
      DCM_CSEL_PIN_1X, DCM_CSEL_PIN_16X: next_s.tick = pin & ~s.pin_q;
      DCM_CSEL_TIMER:                    next_s.tick = timer_out & ~s.timer_q;
      default:                           next_s.tick = rate_tick[dcm_rate_index(code, set2)];
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick  = s.tick;
  assign one_x = s.one_x;

endmodule
`default_nettype wire

// >>> src/dcm_top.sv
// mode-two, clock-select and command logic for both serial channels
// assumes a register port with read data one cycle after the read strobe
//
// Summary of operation
// - mode-two bits 7:6 pick normal/echo/loopbacks
// - bit 5 enables tx rts, bit 4 cts
// - stop field sets stop length in sixteenths
// - external 1x tx clock: one or two stops
// - multidrop puts address flag in parity slot
// - clock code picks rate from baud set
// - rx clock 16x except code 1111 pin
// - tx clock 16x except code 1111 pin
// - command 001 returns mode pointer; 000 idle
// - commands 010/011 reset receiver/transmitter
// - command 100 clears error status
// - command 101 clears break-change interrupt
// - tx field: 00 hold, 01 enable, 10 disable
// - rx field: 00 hold, 01 enable, 10 disable
// - mode access at first register advances pointer
// - error reset clears break/framing/parity status
// - output pins one/zero carry b/a rts
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dcm_top
  import dcm_pkg::*;
#(
  parameter int CLK_HZ = 100_000_000
)(
  // clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  // register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // external clock pins and timer output
  input  wire logic       INPUT_PIN_TWO,
  input  wire logic       INPUT_PIN_THREE,
  input  wire logic       INPUT_PIN_FOUR,
  input  wire logic       INPUT_PIN_FIVE,
  input  wire logic       TIMER_OUT,
  // per-channel state, bit 0 channel a, bit 1 channel b
  output logic      [1:0] RX_ENABLE,
  output logic      [1:0] TX_ENABLE,
  output logic      [1:0] TX_BREAK,
  // per-channel one-cycle command strobes
  output logic      [1:0] RX_RESET,
  output logic      [1:0] TX_RESET,
  output logic      [1:0] ERR_CLEAR,
  output logic      [1:0] BREAK_CHG_CLEAR,
  // per-channel mode outputs
  output logic      [3:0] CHAN_MODE,
  output logic      [1:0] TX_RTS_EN,
  output logic      [1:0] TX_CTS_EN,
  output logic     [11:0] STOP_16THS,
  output logic      [1:0] MULTIDROP,
  // per-channel selected clocks
  output logic      [1:0] RX_TICK,
  output logic      [1:0] TX_TICK,
  output logic      [1:0] RX_1X,
  output logic      [1:0] TX_1X,
  // output pins given over to rts
  output logic            OUTPUT_PIN_ZERO_RTS,
  output logic            OUTPUT_PIN_ONE_RTS
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0] mr1;
    logic [1:0][7:0] mr2;
    logic [1:0][7:0] csel;
    logic [1:0]      ptr;
    logic            set2;
    logic [1:0]      rx_en;
    logic [1:0]      tx_en;
    logic [1:0]      brk;
    logic [1:0]      rx_rst;
    logic [1:0]      tx_rst;
    logic [1:0]      err_clr;
    logic [1:0]      bchg_clr;
    logic [1:0][5:0] stop;
    logic [1:0]      mdrop;
    logic [1:0]      rts_pin;
    logic [7:0]      rdata;
  } dcm_state_t;

  dcm_state_t s;
  dcm_state_t next_s;

  logic [DCM_NUM_RATES-1:0] rate_tick;
  logic                     ch;
  logic [3:0]               reg_sel;
  dcm_misc_t                misc;

  assign ch      = ADDR[DCM_CHAN_BIT];
  assign reg_sel = {1'b0, ADDR[2:0]};
  assign misc    = dcm_misc_t'(WDATA[6:4]);

  // ---------------------------------------------------------------
  // register access and command execution
  // ---------------------------------------------------------------
  always_comb
  begin
    next_s          = s;
    next_s.rdata    = 8'h00;
    next_s.rx_rst   = 2'h0;
    next_s.tx_rst   = 2'h0;
    next_s.err_clr  = 2'h0;
    next_s.bchg_clr = 2'h0;
    // mode register behind the access pointer
    if ((WR || RD) && reg_sel == DCM_OFF_MODE_A)
    begin
      if (WR && s.ptr[ch])
        next_s.mr2[ch] = WDATA;
      else if (WR)
        next_s.mr1[ch] = WDATA;
      if (RD)
        next_s.rdata = s.ptr[ch] ? s.mr2[ch] : s.mr1[ch];
      next_s.ptr[ch] = 1'b1;
    end
    // clock select, write only
    if (WR && reg_sel == DCM_OFF_CSEL_A)
      next_s.csel[ch] = WDATA;
    // baud set lives only at the channel a address
    if (ADDR == DCM_OFF_AUX)
    begin
      if (WR)
        next_s.set2 = WDATA[DCM_AUX_SET_BIT];
      if (RD)
        next_s.rdata = {s.set2, 7'h00};
    end
    // channel state readback
    if (RD && reg_sel == DCM_OFF_STATE_A)
      next_s.rdata = {4'h0, s.ptr[ch], s.brk[ch], s.tx_en[ch], s.rx_en[ch]};
    // command register
    if (WR && reg_sel == DCM_OFF_CMD_A)
    begin
      case (misc)
        DCM_MISC_NONE:        next_s.brk[ch] = s.brk[ch];
        DCM_MISC_PTR_RESET:   next_s.ptr[ch] = 1'b0;
        DCM_MISC_RX_RESET:    next_s.rx_rst[ch] = 1'b1;
        DCM_MISC_TX_RESET:    next_s.tx_rst[ch] = 1'b1;
        DCM_MISC_ERR_RESET:   next_s.err_clr[ch] = 1'b1;
        DCM_MISC_BCHG_RESET:  next_s.bchg_clr[ch] = 1'b1;
        DCM_MISC_BREAK_START: next_s.brk[ch] = 1'b1;
        DCM_MISC_BREAK_STOP:  next_s.brk[ch] = 1'b0;
        default:              next_s.brk[ch] = s.brk[ch];
      endcase
      // transmitter field; 11 is ignored
      if (WDATA[3:2] == DCM_FIELD_ENABLE)
        next_s.tx_en[ch] = 1'b1;
      else if (WDATA[3:2] == DCM_FIELD_DISABLE)
        next_s.tx_en[ch] = 1'b0;
      // receiver field; 11 is ignored
      if (WDATA[1:0] == DCM_FIELD_ENABLE)
        next_s.rx_en[ch] = 1'b1;
      else if (WDATA[1:0] == DCM_FIELD_DISABLE)
        next_s.rx_en[ch] = 1'b0;
      // a reset in the same write wins over an enable
      if (misc == DCM_MISC_RX_RESET)
        next_s.rx_en[ch] = 1'b0;
      if (misc == DCM_MISC_TX_RESET)
      begin
        next_s.tx_en[ch] = 1'b0;
        next_s.brk[ch]   = 1'b0;
      end
    end
    // derived per-channel mode outputs
    for (int c = 0; c < 2; c++)
    begin
      next_s.stop[c]  = dcm_stop_16ths(s.mr2[c][3:0], s.mr1[c][1:0] == DCM_BITS_FIVE,
                                       s.csel[c][3:0] == DCM_CSEL_PIN_1X);
      next_s.mdrop[c] = (s.mr1[c][4:3] == DCM_PAR_MULTIDROP);
      next_s.rts_pin[c] = s.mr2[c][DCM_MR2_RTS_BIT] | s.mr1[c][DCM_MR1_RXRTS];
    end
  end

  // state register
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      s      <= '0;
      s.mr1  <= {DCM_MODE_RESET, DCM_MODE_RESET};
      s.mr2  <= {DCM_MODE_RESET, DCM_MODE_RESET};
      s.csel <= {DCM_CSEL_RESET, DCM_CSEL_RESET};
    end
    else
      s <= next_s;
  end

  // ---------------------------------------------------------------
  // clock generation and selection
  // ---------------------------------------------------------------
  dcm_baud_gen #(
    .CLK_HZ (CLK_HZ)
  ) u_baud (
    .clk  (CLK_SYS),
    .rst  (RST),
    .tick (rate_tick)
  );

  // rx pins: a on pin four, b on pin two; tx pins: a on three, b on five
  logic [1:0] rx_pin;
  logic [1:0] tx_pin;
  assign rx_pin = {INPUT_PIN_TWO, INPUT_PIN_FOUR};
  assign tx_pin = {INPUT_PIN_FIVE, INPUT_PIN_THREE};

  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    dcm_clk_sel u_rx_sel (
      .clk       (CLK_SYS),
      .rst       (RST),
      .code      (s.csel[g][7:4]),
      .set2      (s.set2),
      .rate_tick (rate_tick),
      .timer_out (TIMER_OUT),
      .pin       (rx_pin[g]),
      .tick      (RX_TICK[g]),
      .one_x     (RX_1X[g])
    );
    dcm_clk_sel u_tx_sel (
      .clk       (CLK_SYS),
      .rst       (RST),
      .code      (s.csel[g][3:0]),
      .set2      (s.set2),
      .rate_tick (rate_tick),
      .timer_out (TIMER_OUT),
      .pin       (tx_pin[g]),
      .tick      (TX_TICK[g]),
      .one_x     (TX_1X[g])
    );
  end

  // ---------------------------------------------------------------
  // outputs straight from state
  // ---------------------------------------------------------------
  assign RDATA           = s.rdata;
  assign RX_ENABLE       = s.rx_en;
  assign TX_ENABLE       = s.tx_en;
  assign TX_BREAK        = s.brk;
  assign RX_RESET        = s.rx_rst;
  assign TX_RESET        = s.tx_rst;
  assign ERR_CLEAR       = s.err_clr;
  assign BREAK_CHG_CLEAR = s.bchg_clr;
  assign CHAN_MODE       = {s.mr2[1][7:6], s.mr2[0][7:6]};
  assign TX_RTS_EN       = {s.mr2[1][DCM_MR2_RTS_BIT], s.mr2[0][DCM_MR2_RTS_BIT]};
  assign TX_CTS_EN       = {s.mr2[1][DCM_MR2_CTS_BIT], s.mr2[0][DCM_MR2_CTS_BIT]};
  assign STOP_16THS      = {s.stop[1], s.stop[0]};
  assign MULTIDROP       = s.mdrop;
  assign OUTPUT_PIN_ZERO_RTS = s.rts_pin[0];
  assign OUTPUT_PIN_ONE_RTS  = s.rts_pin[1];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic cmd_a;
  logic cmd_b;
  assign cmd_a = WR && ADDR == DCM_OFF_CMD_A;
  assign cmd_b = WR && ADDR == DCM_OFF_CMD_B;

  ptr_advance_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (WR || RD) && ADDR == DCM_OFF_MODE_A |=> s.ptr[0] ##1 (s.ptr[0] || $past(cmd_a && WDATA[6:4] == 3'h1)))
    else $error("mode pointer did not advance");

  ptr_reset_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_a && WDATA[6:4] == 3'h1 |=> !s.ptr[0])
    else $error("pointer reset command ignored");

  rx_reset_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_a && WDATA[6:4] == 3'h2 |=> RX_RESET[0] && !RX_ENABLE[0] ##1 !RX_RESET[0] || $past(cmd_a))
    else $error("receiver reset strobe wrong");

  err_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_a && WDATA[6:4] == 3'h4 |=> ERR_CLEAR[0] && !BREAK_CHG_CLEAR[0])
    else $error("error clear strobe wrong");

  break_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_a && WDATA[6:4] == 3'h6 |=> TX_BREAK[0] ##1 (TX_BREAK[0] || $past(cmd_a)))
    else $error("break not held");

  tx_enable_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_a && WDATA[3:2] == 2'h1 && WDATA[6:4] != 3'h3 |=> TX_ENABLE[0])
    else $error("transmitter not enabled");

  rx_disable_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_a && WDATA[1:0] == 2'h2 |=> !RX_ENABLE[0])
    else $error("receiver not disabled");

  chan_mode_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    WR && ADDR == DCM_OFF_MODE_A && s.ptr[0] |=> CHAN_MODE[1:0] == $past(WDATA[7:6]))
    else $error("channel mode not stored");

  stop_ext_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $stable(s.csel[0]) && $stable(s.mr2[0]) && s.csel[0][3:0] == 4'hf
      |=> STOP_16THS[5:0] == ($past(s.mr2[0][3]) ? 6'd32 : 6'd16))
    else $error("external clock stop length wrong");

  strobe_once_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    TX_RESET[0] |-> $past(cmd_a && WDATA[6:4] == 3'h3))
    else $error("command strobe longer than one cycle");

  tx_disable_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_a && WDATA[3:2] == 2'h2 |=> !TX_ENABLE[0])
    else $error("transmitter not disabled");

  rx_enable_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_a && WDATA[1:0] == 2'h1 && WDATA[6:4] != 3'h2 |=> RX_ENABLE[0])
    else $error("receiver not enabled");

  break_stop_b_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_b && WDATA[6:4] == 3'h7 |=> !TX_BREAK[1])
    else $error("break not ended");

  bchg_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_a && WDATA[6:4] == 3'h5 |=> BREAK_CHG_CLEAR[0] && !ERR_CLEAR[0])
    else $error("break-change clear strobe wrong");

  rx_reset_b_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cmd_b && WDATA[6:4] == 3'h2 |=> RX_RESET[1] && !RX_ENABLE[1])
    else $error("channel b receiver reset wrong");

  multidrop_flag_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    WR && ADDR == DCM_OFF_MODE_A && !s.ptr[0] |-> ##2 MULTIDROP[0] == ($past(WDATA[4:3], 2) == 2'h3))
    else $error("multidrop flag wrong");

  rts_pin_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    OUTPUT_PIN_ZERO_RTS == $past(s.mr2[0][DCM_MR2_RTS_BIT] | s.mr1[0][DCM_MR1_RXRTS]))
    else $error("rts pin zero wrong");

  rx_clk_16x_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    s.csel[0][7:4] != DCM_CSEL_PIN_1X |=> !RX_1X[0])
    else $error("receiver clock not 16x");

  tx_clk_1x_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    s.csel[0][3:0] == DCM_CSEL_PIN_1X |=> TX_1X[0])
    else $error("transmitter 1x clock not flagged");

endmodule
`default_nettype wire

// >>> tb/dcm_pin_src.sv
// square-wave source standing in for an external clock pin or the timer
// assumes clk is the system clock; the level moves just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module dcm_pin_src #(
  parameter int HALF = 4
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // generated level
  output logic      pin
);
  int cnt;

  // toggle every HALF cycles, held low in reset
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt <= 0;
      pin <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      pin <= ~pin;
    end
    else
      cnt <= cnt + 1;
endmodule
`default_nettype wire

// >>> tb/dcm_top_test.sv
// self-checking bench for the channel mode, clock-select and command block
// assumes dcm_pin_src drives the clock pins and the timer output
`timescale 1ns/1ps
`default_nettype none
module dcm_top_test import dcm_pkg::*; ;
  `define CHK(g, e) chk(16'(g), 16'(e))
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0]  addr = 4'h0, cmode;
  logic [7:0]  wdata = 8'h00, rdata, d;
  wire  [4:0]  pin;
  logic [1:0]  rx_en, tx_en, brk, rx_rst, tx_rst, err_clr, bchg_clr;
  logic [1:0]  rts_en, cts_en, md, rx_tk, tx_tk, rx1, tx1;
  logic [11:0] stop;
  logic        rts0, rts1;
  int          err_total = 0, n_tests = 0, cyc = 0, cnt [4];
  localparam int HALFS [5] = '{3, 4, 5, 6, 10};
  localparam int EXP [2][4] = '{'{200, 36, 50, 50}, '{100, 9, 50, 50}};
  // command rows: address, data, then rx, tx and break state expected
  localparam logic [17:0] ROWS [10] = '{
    {4'h2, 8'h05, 6'b010100}, {4'ha, 8'h65, 6'b111110}, {4'h2, 8'h00, 6'b111110},
    {4'h2, 8'h0a, 6'b101010}, {4'ha, 8'h72, 6'b001000}, {4'h2, 8'h60, 6'b001001},
    {4'h2, 8'h01, 6'b011001}, {4'h2, 8'h34, 6'b011000}, {4'ha, 8'h21, 6'b011000},
    {4'ha, 8'h0a, 6'b010000}};

  // system clock and far-side clock sources
  always #5 clk = ~clk;
  for (genvar i = 0; i < 5; i++)
  begin : g_src
    dcm_pin_src #(.HALF(HALFS[i])) u_dcm_pin_src (.clk(clk), .rst(rst), .pin(pin[i]));
  end

  dcm_top #(.CLK_HZ(1228800)) u_dcm_top (
    .CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .INPUT_PIN_TWO(pin[0]), .INPUT_PIN_THREE(pin[1]), .INPUT_PIN_FOUR(pin[2]),
    .INPUT_PIN_FIVE(pin[3]), .TIMER_OUT(pin[4]), .RX_ENABLE(rx_en), .TX_ENABLE(tx_en),
    .TX_BREAK(brk), .RX_RESET(rx_rst), .TX_RESET(tx_rst), .ERR_CLEAR(err_clr),
    .BREAK_CHG_CLEAR(bchg_clr), .CHAN_MODE(cmode), .TX_RTS_EN(rts_en), .TX_CTS_EN(cts_en),
    .STOP_16THS(stop), .MULTIDROP(md), .RX_TICK(rx_tk), .TX_TICK(tx_tk), .RX_1X(rx1),
    .TX_1X(tx1), .OUTPUT_PIN_ZERO_RTS(rts0), .OUTPUT_PIN_ONE_RTS(rts1));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // count ticks: rx a, rx b, tx a, tx b
  task automatic window(input int n);
    cnt = '{default: 0};
    repeat (n)
    begin
      idle(1);
      for (int i = 0; i < 2; i++)
      begin
        cnt[i]     += int'(rx_tk[i]);
        cnt[i + 2] += int'(tx_tk[i]);
      end
    end
  endtask

  function automatic bit near(input int g, input int e);
    return g >= e - 1 && g <= e + 1;
  endfunction

  function automatic logic [5:0] exp_stop(input logic [3:0] c, input bit five, input bit ext);
    if (ext)
      return c[3] ? 6'h20 : 6'h10;
    return (c[3] ? 6'h19 : five ? 6'h11 : 6'h09) + {3'h0, c[2:0]};
  endfunction

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    `CHK({rx_en, tx_en, brk, rx_rst, tx_rst, err_clr, bchg_clr}, 0);
    `CHK({cmode, rts_en, md, rx1, tx1, rts0, rts1}, 0);
    rst <= 1'b0;
    // command rows; tx field 11 is never written
    foreach (ROWS[i])
    begin
      wr_reg(ROWS[i][17:14], ROWS[i][13:6]);
      `CHK({rx_en, tx_en, brk}, ROWS[i][5:0]);
    end
    rd_reg(DCM_OFF_STATE_A, d);
    `CHK(d, 8'h01);
    $display("command rows done");
    // one-shot misc commands on both channels
    for (int m = 2; m < 6; m++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        wr_reg(c[0] ? DCM_OFF_CMD_B : DCM_OFF_CMD_A, {1'b0, 3'(m), 4'h0});
        `CHK({bchg_clr, err_clr, tx_rst, rx_rst}, 8'h01 << (2 * (m - 2) + c));
        idle(1);
        `CHK({bchg_clr, err_clr, tx_rst, rx_rst}, 0);
      end
    end
    rd_reg(DCM_OFF_CSEL_A, d);
    `CHK(d, 0);
    rd_reg(4'hc, d);
    `CHK(d, 0);
    $display("strobes done");
    // mode pointer, mode-one and mode-two fields of channel a, then channel b mode
    rd_reg(DCM_OFF_MODE_A, d);
    `CHK(d, 0);
    wr_reg(DCM_OFF_MODE_A, 8'he5);
    `CHK({cmode[1:0], rts_en[0], cts_en[0]}, 4'b1110);
    rd_reg(DCM_OFF_MODE_A, d);
    `CHK(d, 8'he5);
    wr_reg(DCM_OFF_CMD_A, 8'h10);
    wr_reg(DCM_OFF_MODE_A, 8'h98);
    idle(1);
    `CHK({md[0], rts0}, 2'b11);
    rd_reg(DCM_OFF_MODE_A, d);
    `CHK(d, 8'he5);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(DCM_OFF_MODE_A, {2'(m), 6'h10});
      `CHK({cmode[1:0], rts_en[0], cts_en[0]}, {2'(m), 2'b01});
    end
    for (int f = 1; f >= 0; f--)
    begin
      for (int c = 0; c < 16; c++)
      begin
        wr_reg(DCM_OFF_MODE_A, {4'h0, 4'(c)});
        idle(1);
        `CHK(stop[5:0], exp_stop(4'(c), f[0], 1'b0));
      end
      wr_reg(DCM_OFF_CMD_A, 8'h10);
      wr_reg(DCM_OFF_MODE_A, 8'h1b);
    end
    idle(1);
    `CHK(rts0, 0);
    wr_reg(DCM_OFF_CSEL_A, 8'h0f);
    for (int c = 7; c < 9; c++)
    begin
      wr_reg(DCM_OFF_MODE_A, {4'h0, 4'(c)});
      idle(1);
      `CHK({tx1, stop[5:0]}, {2'b01, exp_stop(4'(c), 1'b0, 1'b1)});
    end
    wr_reg(DCM_OFF_MODE_B, 8'h80);
    idle(1);
    `CHK({rts1, cmode[3:2]}, 3'b100);
    $display("mode fields done");
    // external pins and timer as clock sources
    wr_reg(DCM_OFF_CSEL_A, 8'hef);
    wr_reg(DCM_OFF_CSEL_B, 8'hed);
    idle(4);
    `CHK({rx1, tx1}, 4'b0001);
    window(240);
    `CHK({near(cnt[0], 24), near(cnt[1], 40), near(cnt[2], 30), near(cnt[3], 12)}, 4'hf);
    $display("pin sources done");
    // both baud sets, channels picked independently
    wr_reg(DCM_OFF_CSEL_A, 8'hcb);
    wr_reg(DCM_OFF_CSEL_B, 8'hab);
    for (int s = 0; s < 2; s++)
    begin
      wr_reg(DCM_OFF_AUX, {s[0], 7'h00});
      idle(4);
      window(400);
      for (int k = 0; k < 4; k++)
        `CHK(near(cnt[k], EXP[s][k]), 1);
    end
    $display("baud rates done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
